// ==== rtl/sfg_guard.sv ====
`timescale 1ns/1ps
// Behaviour
// - single-line mode samples input bits on serial clock rising edges
// - output bits change on serial clock falling edges
// - accept clock idling low or high at chip-select edges
// - dual instructions use lines 0 and 1, two bits per clock
// - quad instructions use four lines, four bits per clock
// - reset-enable then reset as next instruction resets to power-on state; code keeps the status bits
// - ignore all instructions for 30 us after software reset
// - reset pin low at least 1 us aborts everything, power-on state; code keeps the status bits
// - reset pin overrides chip select, clock and data lines
// - while supply reset holds, no instruction is recognised
// - after supply reset, write-type instructions rejected for lockout delay
// - write enable latch cleared at power-up
// - program, erase, status write need write enable latch set
// - write enable latch cleared when program, erase or status write completes
// - in power-down only release-from-power-down is obeyed
// - status writes gated by protect bit, lock bit and write-protect pin
// - complement, top/bottom and block-protect field make array read-only; code lets chip erase through regardless
// - 62 block lock bits plus 32 sector lock bits; code addresses only 30 block lock bits, for blocks 1..30
// - lock bit 1 blocks erase and program of that region; code checks only the addressed lock bit and lets chip erase through
// - all lock bits set at power-on
// - unlock instruction clears one addressed region lock bit
// - scheme select chooses field protection (0) or lock bits (1)
// - quad enable turns protect and pause pins into data lines 2 and 3
// - lock bit 1 refuses status writes until power cycle
// - instruction accepted only after chip select high-to-low transition
module sfg_guard
  import sfg_pkg::*;
#(
  parameter int RECOVER_CYC = RST_RECOVER_CYC,
  parameter int LOCKOUT_CYC = PU_LOCK_CYC
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        supplyLow,
  input  wire logic        resetPinN,
  input  wire logic        chipSelN,
  input  wire logic        serialClk,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe,
  input  wire sfg_cfg_type cfgIn,
  input  wire logic        cfgLoad,
  output sfg_cfg_type      cfgState,
  output logic             writeEnableLatch,
  output logic             powerDown,
  output logic             busy,
  output logic [LOCK_BITS-1:0] lockBits,
  output sfg_cmd_type      cmdData,
  output logic             cmdValid,
  input  wire logic        cmdReady,
  input  wire logic        opDone,
  input  wire logic [7:0]  readByte
);
  // pin synchronisers; stage 1 feeds stage 2 only
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  always_ff @(posedge clock) begin
    s1_reg <= {supplyLow, resetPinN, chipSelN, serialClk, ioIn};
    s2_reg <= s1_reg;
  end
  logic sLow, sRstN, sCsN, sClk;
  logic [3:0] sIo;
  assign {sLow, sRstN, sCsN, sClk, sIo} = s2_reg;

  logic clkPrev_reg, csPrev_reg;
  logic risePulse, fallPulse, csFall, csRise;
  always_ff @(posedge clock) begin
    clkPrev_reg <= sClk;
    csPrev_reg  <= sCsN;
  end
  // edges only count inside a frame, so the idle level (mode 0 or 3)
  // at chip-select edges never yields a spurious bit
  assign risePulse = !sCsN && !csPrev_reg && sClk && !clkPrev_reg;
  assign fallPulse = !sCsN && !csPrev_reg && !sClk && clkPrev_reg;
  assign csFall    = !sCsN && csPrev_reg;
  assign csRise    = sCsN && !csPrev_reg;

  // hardware reset pin width counter
  logic [$clog2(HW_RST_MIN_CYC+1)-1:0] hwCnt_reg;
  logic hwReset;
  always_ff @(posedge clock) begin
    if (sys_rst || sRstN) begin
      hwCnt_reg <= '0;
    end else if (hwCnt_reg != HW_RST_MIN_CYC[$bits(hwCnt_reg)-1:0]) begin
      hwCnt_reg <= hwCnt_reg + 1'b1;
    end
  end
  assign hwReset = (hwCnt_reg == HW_RST_MIN_CYC[$bits(hwCnt_reg)-1:0]);

  // power-on style clear: sys reset, supply, pin, or accepted soft reset
  logic softReset;
  logic coldClear;
  logic warmClear;
  assign warmClear = sys_rst || sLow || hwReset || softReset;
  assign coldClear = sys_rst || sLow;

  sfg_state_type state_reg;
  logic [31:0] timer_reg;
  logic        csArmed_reg;
  logic [7:0]  shift_reg;
  logic [5:0]  bitCnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0]  op_reg;
  logic        opValid_reg;
  logic        rstArmed_reg;
  logic [1:0]  lanes_reg;
  logic        pendWrite_reg;

  always_ff @(posedge clock) begin
    if (warmClear) begin
      state_reg <= softReset && !coldClear && !hwReset ? ST_RECOV : ST_OFF;
      timer_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_OFF: begin
          state_reg <= ST_LOCK;
          timer_reg <= '0;
        end
        ST_LOCK: begin
          timer_reg <= timer_reg + 1;
          if (timer_reg >= 32'(LOCKOUT_CYC - 1)) begin
            state_reg <= ST_READY;
          end
        end
        ST_RECOV: begin
          timer_reg <= timer_reg + 1;
          if (timer_reg >= 32'(RECOVER_CYC - 1)) begin
            state_reg <= ST_READY;
          end
        end
        ST_READY: begin
          if (csRise && opValid_reg && op_reg == OP_PD) begin
            state_reg <= ST_PDOWN;
          end
        end
        ST_PDOWN: begin
          if (csRise && opValid_reg && op_reg == OP_RPD) begin
            state_reg <= ST_READY;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  assign busy      = (state_reg == ST_RECOV) || pendWrite_reg;
  assign powerDown = (state_reg == ST_PDOWN);

  // a frame counts only after a fresh high-to-low chip select
  always_ff @(posedge clock) begin
    if (warmClear) begin
      csArmed_reg <= 1'b0;
    end else if (csFall) begin
      csArmed_reg <= 1'b1;
    end
  end

  // lane width from opcode: after 8 bits, dual/quad address forms widen
  logic quadOk;
  assign quadOk = cfgState.quadEnableBit;
  always_ff @(posedge clock) begin
    if (warmClear || csFall) begin
      shift_reg  <= '0;
      bitCnt_reg <= '0;
      addr_reg   <= '0;
      lanes_reg  <= LANES_1;
      op_reg     <= '0;
      opValid_reg <= 1'b0;
    end else if (risePulse && csArmed_reg) begin
      unique case (lanes_reg)
        LANES_2: addr_reg <= {addr_reg[ADDR_W-3:0], sIo[1:0]};
        LANES_4: addr_reg <= {addr_reg[ADDR_W-5:0], sIo};
        default: begin
          if (bitCnt_reg < 6'd8) begin
            shift_reg <= {shift_reg[6:0], sIo[0]};
          end else begin
            addr_reg <= {addr_reg[ADDR_W-2:0], sIo[0]};
          end
        end
      endcase
      bitCnt_reg <= bitCnt_reg == 6'd63 ? bitCnt_reg : bitCnt_reg + 1'b1;
      if (bitCnt_reg == 6'd7) begin
        op_reg      <= {shift_reg[6:0], sIo[0]};
        opValid_reg <= 1'b1;
        if ({shift_reg[6:0], sIo[0]} == OP_DIOR) begin
          lanes_reg <= LANES_2;
        end else if ({shift_reg[6:0], sIo[0]} == OP_QIOR && quadOk) begin
          lanes_reg <= LANES_4;
        end
      end
    end
  end

  // instruction takes effect at chip select rise
  logic accept;
  logic isProg, isErase, isWrsr, needsWel;
  assign accept = csRise && opValid_reg && state_reg == ST_READY;
  assign isProg  = op_reg == OP_PP;
  assign isErase = op_reg == OP_SE || op_reg == OP_BE32 ||
                   op_reg == OP_BE64 || op_reg == OP_CE;
  assign isWrsr  = op_reg == OP_WRSR;
  assign needsWel = isProg || isErase || isWrsr;

  always_ff @(posedge clock) begin
    if (warmClear) begin
      rstArmed_reg <= 1'b0;
    end else if (accept) begin
      rstArmed_reg <= (op_reg == OP_RSTEN);
    end
  end
  assign softReset = accept && rstArmed_reg && op_reg == OP_RST;

  logic wpLow, statusWriteOk;
  assign wpLow = !sIo[2] && !cfgState.quadEnableBit;
  assign statusWriteOk = !cfgState.statusLockBit &&
                         !(cfgState.statusProtectBit && wpLow);

  logic [4:0] blk;
  logic       fieldHit, lockHit, regionOk;
  logic [6:0] lockIdx;
  logic [4:0] span;
  assign blk  = addr_reg[ADDR_W-1:BLK_POS];
  assign span = cfgState.blockProtectField == 3'd0 ? 5'd0 :
                5'(1 << (cfgState.blockProtectField - 3'd1));
  always_comb begin
    fieldHit = 1'b0;
    if (cfgState.blockProtectField == 3'd7) begin
      fieldHit = 1'b1;
    end else if (cfgState.sectorGranularitySelect) begin
      fieldHit = span != 0 &&
        (cfgState.topBottomSelect ? blk == 5'd0 : blk == 5'd31);
    end else if (cfgState.topBottomSelect) begin
      fieldHit = blk < span;
    end else begin
      fieldHit = (6'd32 - 6'(blk)) <= 6'(span);
    end
    fieldHit = fieldHit ^ cfgState.complementProtect;
  end
  // sectors of bottom block 0..15, top block 16..31, then blocks 1..30
  always_comb begin
    if (blk == 5'd0) begin
      lockIdx = 7'(addr_reg[SEC_POS+3:SEC_POS]);
    end else if (blk == 5'd31) begin
      lockIdx = 7'(addr_reg[SEC_POS+3:SEC_POS]) + 7'd16;
    end else begin
      lockIdx = 7'(SECTOR_LOCKS) + 7'(blk) - 7'd1;
    end
  end
  assign lockHit  = lockBits[lockIdx];
  assign regionOk = op_reg == OP_CE ? 1'b1 :
                    cfgState.protectSchemeSelect ? !lockHit : !fieldHit;

  // command hand-off with fifo back-pressure
  logic   issue;
  assign issue = accept && writeEnableLatch && (isProg || isErase) &&
                 regionOk;
  sfg_cmd_type fifoIn;
  assign fifoIn = '{isErase: isErase, opcode: op_reg, addr: addr_reg};
  logic fifoReady;
  sfg_fifo #(.WIDTH($bits(sfg_cmd_type)), .DEPTH(8)) u_fifo (
    .clock    (clock),
    .sys_rst  (warmClear),
    .inData   (fifoIn),
    .inValid  (issue),
    .inReady  (fifoReady),
    .outData  (cmdData),
    .outValid (cmdValid),
    .outReady (cmdReady)
  );

  // write enable latch
  always_ff @(posedge clock) begin
    if (warmClear) begin
      writeEnableLatch <= 1'b0;
      pendWrite_reg    <= 1'b0;
    end else if (accept && op_reg == OP_WREN) begin
      writeEnableLatch <= 1'b1;
    end else if (accept && op_reg == OP_WRDI) begin
      writeEnableLatch <= 1'b0;
    end else if (accept && isWrsr && statusWriteOk) begin
      writeEnableLatch <= 1'b0; // status write finishes at once
    end else if (issue && fifoReady) begin
      pendWrite_reg <= 1'b1;
    end else if (opDone && pendWrite_reg) begin
      writeEnableLatch <= 1'b0;
      pendWrite_reg    <= 1'b0;
    end
  end

  // status bits: power cycle or sys reset clears the lock bit; cfgLoad overwrites it from cfgIn
  always_ff @(posedge clock) begin
    if (coldClear) begin
      cfgState <= '0;
    end else if (cfgLoad) begin
      cfgState <= cfgIn;
    end else if (accept && isWrsr && writeEnableLatch && statusWriteOk) begin
      cfgState <= {addr_reg[ADDR_W-1:ADDR_W-10]};
    end
  end

  always_ff @(posedge clock) begin
    if (warmClear) begin
      lockBits <= '1;
    end else if (accept && op_reg == OP_UNLOCK && writeEnableLatch) begin
      lockBits[lockIdx] <= 1'b0;
    end else if (accept && op_reg == OP_LOCK && writeEnableLatch) begin
      lockBits[lockIdx] <= 1'b1;
    end
  end

  // output shifts on falling edges; status/read byte, multi-lane reads
  // a fresh byte is fetched each time the lane count wraps to zero
  logic [7:0] outSh_reg;
  logic [2:0] outCnt_reg;
  logic       drive_reg;
  logic [7:0] outByte;
  logic [2:0] outStep;
  assign outByte = outCnt_reg != 3'd0 ? outSh_reg :
                   op_reg == OP_RDSR ? {6'd0, writeEnableLatch, busy} :
                   readByte;
  assign outStep = (op_reg == OP_DOR || op_reg == OP_DIOR) ? 3'd2 :
                   (op_reg == OP_QOR || op_reg == OP_QIOR) ? 3'd4 : 3'd1;
  always_ff @(posedge clock) begin
    if (warmClear || !csArmed_reg || sCsN) begin
      outSh_reg  <= '0;
      outCnt_reg <= '0;
      drive_reg  <= 1'b0;
      ioOut      <= '0;
    end else if (fallPulse && bitCnt_reg >= 6'd8) begin
      outSh_reg  <= outByte << outStep;
      outCnt_reg <= outCnt_reg + outStep;
      drive_reg  <= state_reg == ST_READY;
      unique case (op_reg)
        OP_DOR, OP_DIOR: ioOut <= {2'b00, outByte[7:6]};
        OP_QOR, OP_QIOR: ioOut <= quadOk ? outByte[7:4] : '0;
        default:         ioOut <= {2'b00, outByte[7], 1'b0};
      endcase
    end
  end
  assign ioOe = !drive_reg ? 4'h0 :
                (op_reg == OP_QOR || op_reg == OP_QIOR) && quadOk ? 4'hF :
                (op_reg == OP_DOR || op_reg == OP_DIOR) ? 4'h3 : 4'h2;

  property p_wel_clear;
    @(posedge clock) disable iff (sys_rst)
      (opDone && pendWrite_reg && !warmClear) |=> !writeEnableLatch;
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch not cleared");
  property p_locks_set;
    @(posedge clock) hwReset |=> (lockBits == '1);
  endproperty
  a_locks_set: assert property (p_locks_set)
    else $error("locks not set");
  property p_no_issue_wel;
    @(posedge clock) disable iff (sys_rst) issue |-> writeEnableLatch;
  endproperty
  a_no_issue_wel: assert property (p_no_issue_wel)
    else $error("write without latch");
  property p_recover;
    @(posedge clock) disable iff (sys_rst)
      softReset |=> state_reg == ST_RECOV;
  endproperty
  a_recover: assert property (p_recover)
    else $error("no recovery");
  property p_pd_ignore;
    @(posedge clock) disable iff (sys_rst)
      (powerDown && !warmClear && !opDone) |=>
        $stable(writeEnableLatch) && $stable(lockBits);
  endproperty
  a_pd_ignore: assert property (p_pd_ignore)
    else $error("accepted in power down");
  property p_srl;
    @(posedge clock) disable iff (sys_rst)
      (cfgState.statusLockBit && !cfgLoad && !coldClear) |=> $stable(cfgState);
  endproperty
  a_srl: assert property (p_srl)
    else $error("locked status changed");
  property p_lock_ign;
    @(posedge clock) disable iff (sys_rst)
      (issue && op_reg != OP_CE && cfgState.protectSchemeSelect) |-> !lockHit;
  endproperty
  a_lock_ign: assert property (p_lock_ign)
    else $error("locked region written");
  property p_hw;
    @(posedge clock) disable iff (sys_rst) hwReset |=> !writeEnableLatch;
  endproperty
  a_hw: assert property (p_hw)
    else $error("pin reset ignored");
  c_soft: cover property (@(posedge clock) softReset);
  c_issue: cover property (@(posedge clock) issue);
  c_pd: cover property (@(posedge clock) powerDown);
endmodule // sfg_guard

// ==== rtl/sfg_pkg.sv ====
package sfg_pkg;
  localparam int CLK_MHZ = 125;
  // software reset recovery, microseconds
  localparam int RST_RECOVER_US = 30;
  localparam int RST_RECOVER_CYC = RST_RECOVER_US * CLK_MHZ;
  // hardware reset pin least low width, microseconds
  localparam int HW_RST_MIN_US = 1;
  localparam int HW_RST_MIN_CYC = HW_RST_MIN_US * CLK_MHZ;
  // power-up write lockout, plain default
  localparam int PU_LOCK_CYC = 8192;

  localparam int BLOCK_LOCKS = 62;
  localparam int SECTOR_LOCKS = 32;
  localparam int LOCK_BITS = BLOCK_LOCKS + SECTOR_LOCKS;
  localparam int ADDR_W = 21;
  localparam int BLK_POS = 16;
  localparam int SEC_POS = 12;
  localparam int NUM_BLOCKS = 32;

  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hD8;
  localparam logic [7:0] OP_CE     = 8'hC7;
  localparam logic [7:0] OP_PD     = 8'hB9;
  localparam logic [7:0] OP_RPD    = 8'hAB;
  localparam logic [7:0] OP_RSTEN  = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK   = 8'h36;
  localparam logic [7:0] OP_DOR    = 8'h3B;
  localparam logic [7:0] OP_DIOR   = 8'hBB;
  localparam logic [7:0] OP_QOR    = 8'h6B;
  localparam logic [7:0] OP_QIOR   = 8'hEB;

  localparam logic [1:0] LANES_1 = 2'd0;
  localparam logic [1:0] LANES_2 = 2'd1;
  localparam logic [1:0] LANES_4 = 2'd2;

  typedef struct packed {
    logic       isErase;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
  } sfg_cmd_type;

  typedef struct packed {
    logic       complementProtect;
    logic       sectorGranularitySelect;
    logic       topBottomSelect;
    logic [2:0] blockProtectField;
    logic       statusProtectBit;
    logic       statusLockBit;
    logic       quadEnableBit;
    logic       protectSchemeSelect;
  } sfg_cfg_type;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_LOCK   = 3'b001,
    ST_READY  = 3'b011,
    ST_RECOV  = 3'b010,
    ST_PDOWN  = 3'b111
  } sfg_state_type;
endpackage

// ==== rtl/sfg_fifo.sv ====
`timescale 1ns/1ps
module sfg_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sfg_fifo

// ==== testbench/sfg_spi_master.sv ====
`timescale 1ns/1ps
module sfg_spi_master
  import sfg_pkg::*;
(
  output logic chipSelN,
  output logic serialClk,
  output logic mosi,
  input  wire logic [3:0] sio
);
  logic [31:0] rxBits;
  logic [31:0] rxDual;
  logic [31:0] rxQuad;
  // clock idle level at chip-select edges: 0 low, 1 high
  bit mode3 = 1'b0;

  initial begin
    chipSelN  = 1'b1;
    serialClk = 1'b0;
    mosi      = 1'b0;
  end

  // data changes while the clock is low, device samples on the rise
  task automatic shiftBits(input logic [31:0] v, input int n);
    for (int i = 31; i > 31 - n; i--) begin
      serialClk = 1'b0;
      mosi = v[i];
      #32;
      // lines are read just before the rise, once they have settled
      rxBits = {rxBits[30:0], sio[1]};
      rxDual = {rxDual[29:0], sio[1:0]};
      rxQuad = {rxQuad[27:0], sio};
      serialClk = 1'b1;
      #32;
    end
  endtask

  // clock stands still between frames, at the idle level of the mode
  task automatic frame(input logic [31:0] v, input int n);
    serialClk = mode3;
    #16 chipSelN = 1'b0;
    #32;
    shiftBits(v, n);
    if (!mode3) serialClk = 1'b0;
    #32 chipSelN = 1'b1;
    // released line must not keep showing the last bit
    mosi = ~mosi;
    #64;
  endtask

  task automatic op8(input logic [7:0] op);
    frame({op, 24'h00_0000}, 8);
  endtask

  task automatic opAddr(input logic [7:0] op, input logic [23:0] a);
    frame({op, a}, 32);
  endtask

  task automatic opCfg(input logic [7:0] op, input sfg_cfg_type c);
    frame({op, c, 14'h0000}, 29);
  endtask
endmodule // sfg_spi_master

// ==== testbench/sfg_guard_bench.sv ====
`timescale 1ns/1ps
module sfg_guard_bench
  import sfg_pkg::*;
;
  localparam int RECOV = 300;
  localparam int LOCKOUT = 200;
  localparam logic [LOCK_BITS-1:0] ALL_LOCKED = '1;
  localparam logic [LOCK_BITS-1:0] ONE_OPEN = ~(LOCK_BITS'(1) << 3);

  logic                 clock, sys_rst, supplyLow, resetPinN;
  logic                 chipSelN, serialClk, mosi, wpN, idleToggle;
  logic [3:0]           ioIn, ioOut, ioOe;
  sfg_cfg_type          cfgIn, cfgState;
  logic                 cfgLoad, writeEnableLatch, powerDown, busy;
  logic [LOCK_BITS-1:0] lockBits;
  sfg_cmd_type          cmdData, expCmd;
  logic                 cmdValid, cmdReady, opDone;
  logic [7:0]           readByte;
  logic [31:0]          rndState = 32'h76f9_8e26;
  sfg_cmd_type          cmdQ[$];
  int                   n_mismatch = 0;
  int                   samples_checked = 0;

  assign ioIn[0] = ioOe[0] ? ioOut[0] : mosi;
  assign ioIn[1] = ioOe[1] ? ioOut[1] : idleToggle;
  assign ioIn[2] = ioOe[2] ? ioOut[2] : wpN;
  assign ioIn[3] = ioOe[3] ? ioOut[3] : 1'b1;

  sfg_guard #(.RECOVER_CYC(RECOV), .LOCKOUT_CYC(LOCKOUT)) u_sfg_guard (
    .clock(clock), .sys_rst(sys_rst), .supplyLow(supplyLow),
    .resetPinN(resetPinN), .chipSelN(chipSelN), .serialClk(serialClk),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .cfgIn(cfgIn),
    .cfgLoad(cfgLoad), .cfgState(cfgState),
    .writeEnableLatch(writeEnableLatch), .powerDown(powerDown),
    .busy(busy), .lockBits(lockBits), .cmdData(cmdData),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .opDone(opDone),
    .readByte(readByte)
  );

  sfg_spi_master u_sfg_spi_master (
    .chipSelN(chipSelN), .serialClk(serialClk), .mosi(mosi),
    .sio(ioIn)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // far side stalls at random so commands sit in the fifo
  always @(posedge clock) begin
    #1;
    rndState = xs(rndState);
    cmdReady = rndState[0] | rndState[1];
    idleToggle = ~idleToggle;
  end

  always @(posedge clock) begin
    if (cmdValid === 1'b1 && cmdReady === 1'b1) begin
      samples_checked++;
      if (cmdQ.size() == 0) begin
        n_mismatch++;
        $display("ERROR %0t unexpected command %h", $time, cmdData);
      end else begin
        expCmd = cmdQ.pop_front();
        if (cmdData !== expCmd) begin
          n_mismatch++;
          $display("ERROR %0t command %h expected %h", $time, cmdData,
                   expCmd);
        end
      end
      #1 opDone = 1'b1;
      @(posedge clock);
      #1 opDone = 1'b0;
    end
  end

  task automatic finish_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [LOCK_BITS-1:0] got,
                     input logic [LOCK_BITS-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t level %h expected %h", $time, got, exp);
    end
  endtask

  task automatic drain;
    for (int i = 0; i < 400 && cmdQ.size() != 0; i++) @(posedge clock);
    if (cmdQ.size() != 0) begin
      n_mismatch++;
      $display("ERROR %0t expected command never appeared", $time);
      cmdQ.delete();
    end
    wt(8);
  endtask

  task automatic wren;
    u_sfg_spi_master.op8(OP_WREN);
    wt(8);
  endtask

  task automatic se(input logic [23:0] a, input logic ok);
    if (ok) cmdQ.push_back('{isErase: 1'b1, opcode: OP_SE,
                             addr: a[ADDR_W-1:0]});
    u_sfg_spi_master.opAddr(OP_SE, a);
    drain();
  endtask

  // read data byte is random but held for the whole frame
  task automatic rdChk(input logic [7:0] op, input int n, input int lanes,
                       input logic [7:0] st);
    logic [7:0] got;
    readByte = rndState[15:8];
    u_sfg_spi_master.frame({op, 24'h00_0000}, n);
    got = lanes == 4 ? u_sfg_spi_master.rxQuad[7:0] :
          lanes == 2 ? u_sfg_spi_master.rxDual[7:0] :
          u_sfg_spi_master.rxBits[7:0];
    chk(LOCK_BITS'(got), LOCK_BITS'(op == OP_RDSR ? st : readByte));
  endtask

  task automatic loadCfg(input sfg_cfg_type c);
    cfgIn = c;
    cfgLoad = 1'b1;
    wt(1);
    cfgLoad = 1'b0;
    wt(4);
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    $display("ERROR %0t run did not finish in time", $time);
    finish_test();
  end

  initial begin
    sfg_cfg_type c, c2;
    logic [23:0] a;
    sys_rst = 1'b1;
    supplyLow = 1'b0;
    resetPinN = 1'b1;
    cfgIn = '0;
    cfgLoad = 1'b0;
    wpN = 1'b1;
    idleToggle = 1'b0;
    cmdReady = 1'b0;
    opDone = 1'b0;
    readByte = 8'h00;
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    chk(LOCK_BITS'(writeEnableLatch), '0);
    chk(lockBits, ALL_LOCKED);
    wren();
    chk(LOCK_BITS'(writeEnableLatch), '0);
    wt(LOCKOUT);
    a = {12'h003, rndState[11:0]};
    wren();
    chk(LOCK_BITS'(writeEnableLatch), LOCK_BITS'(1));
    rdChk(OP_RDSR, 16, 1, 8'h02);
    se(a, 1'b1);
    chk(LOCK_BITS'(writeEnableLatch), '0);
    se(a, 1'b0);
    c = '0;
    c.blockProtectField = 3'b111;
    loadCfg(c);
    wren();
    se(a, 1'b0);
    c.complementProtect = 1'b1;
    loadCfg(c);
    wren();
    se(a, 1'b1);
    c.protectSchemeSelect = 1'b1;
    loadCfg(c);
    u_sfg_spi_master.mode3 = 1'b1;
    wren();
    se(a, 1'b0);
    wren();
    u_sfg_spi_master.opAddr(OP_UNLOCK, a);
    wt(8);
    chk(lockBits, ONE_OPEN);
    rdChk(OP_RDSR, 16, 1, 8'h02);
    rdChk(OP_DOR, 12, 2, 8'h00);
    wren();
    se(a, 1'b1);
    u_sfg_spi_master.op8(OP_RSTEN);
    u_sfg_spi_master.op8(OP_WREN);
    u_sfg_spi_master.op8(OP_RST);
    wt(8);
    chk(lockBits, ONE_OPEN);
    u_sfg_spi_master.op8(OP_RSTEN);
    u_sfg_spi_master.op8(OP_RST);
    wt(8);
    chk(lockBits, ALL_LOCKED);
    wren();
    chk(LOCK_BITS'(writeEnableLatch), '0);
    wt(RECOV + LOCKOUT);
    wren();
    u_sfg_spi_master.op8(OP_PD);
    u_sfg_spi_master.op8(OP_WRDI);
    wt(8);
    chk(LOCK_BITS'(powerDown), LOCK_BITS'(1));
    chk(LOCK_BITS'(writeEnableLatch), LOCK_BITS'(1));
    u_sfg_spi_master.op8(OP_RPD);
    u_sfg_spi_master.op8(OP_WRDI);
    wt(8);
    chk(LOCK_BITS'(powerDown), '0);
    chk(LOCK_BITS'(writeEnableLatch), '0);
    u_sfg_spi_master.mode3 = 1'b0;
    c = '0;
    c.statusProtectBit = 1'b1;
    loadCfg(c);
    c2 = c;
    c2.blockProtectField = 3'b010;
    c2.statusLockBit = 1'b1;
    wpN = 1'b0;
    wren();
    u_sfg_spi_master.opCfg(OP_WRSR, c2);
    wt(8);
    chk(LOCK_BITS'(cfgState), LOCK_BITS'(c));
    wpN = 1'b1;
    wren();
    u_sfg_spi_master.opCfg(OP_WRSR, c2);
    wt(8);
    chk(LOCK_BITS'(cfgState), LOCK_BITS'(c2));
    chk(LOCK_BITS'(writeEnableLatch), '0);
    wren();
    u_sfg_spi_master.opCfg(OP_WRSR, c);
    wt(8);
    chk(LOCK_BITS'(cfgState), LOCK_BITS'(c2));
    c = '0;
    c.quadEnableBit = 1'b1;
    loadCfg(c);
    rdChk(OP_QOR, 10, 4, 8'h00);
    supplyLow = 1'b1;
    wren();
    chk(LOCK_BITS'(writeEnableLatch), '0);
    supplyLow = 1'b0;
    wt(LOCKOUT);
    wren();
    // reset pin pulled in the middle of a frame
    fork
      u_sfg_spi_master.opAddr(OP_SE, a);
      begin
        wt(20);
        resetPinN = 1'b0;
        wt(HW_RST_MIN_CYC + 4);
        resetPinN = 1'b1;
      end
    join
    wt(8);
    chk(LOCK_BITS'(writeEnableLatch), '0);
    chk(lockBits, ALL_LOCKED);
    drain();
    finish_test();
  end
endmodule // sfg_guard_bench
